// ### design/crau_defs.svh
`ifndef CRAU_DEFS_SVH
`define CRAU_DEFS_SVH
// control register space layout
`define CRAU_NREG        16
`define CRAU_IDX_W       4
`define CRAU_BASE        32'hFFFF0000
`define CRAU_BASE_MASK   32'hFFFFFFC0
`define CRAU_IDX_LSB     2
`define CRAU_WORD_BYTES  3'h4
`define CRAU_PSW_IDX     4'h0
`define CRAU_SAVED_IDX   4'h1
`define CRAU_SPC_IDX     4'h2
`define CRAU_LOCK_IDX    4'h3
`define CRAU_ID_IDX      4'h4
`define CRAU_NDEF        4'hA
// read permission per index, one bit each; id reads, lock word reads
`define CRAU_RD_ALLOW    16'h03FF
// write permission: id register (index 4) is read only
`define CRAU_WR_ALLOW    16'h03EF
`define CRAU_LOCK_BIT    0
// id value is arbitrary and names no real part
`define CRAU_ID_VALUE    32'h00000A5A
`define CRAU_PSW_RESET   32'h00000000
`define CRAU_ZERO        32'h00000000
`endif

// ### design/crau_pkg.sv
package crau_pkg;
   typedef enum logic [2:0]
   {
      CRAU_OP_NONE,
      CRAU_OP_READ,
      CRAU_OP_WRITE,
      CRAU_OP_MASKED_STATUS_UPDATE,
      CRAU_OP_RFI,
      CRAU_OP_ISYNC,
      CRAU_OP_LOCKWAIT,
      CRAU_OP_RETAIN
   } crau_op_t;
   typedef enum logic [1:0]
   {
      CRAU_FAULT_NONE,
      CRAU_FAULT_UNMAPPED,
      CRAU_FAULT_PERMISSION
   } crau_fault_t;
endpackage

// ### design/crau_check.sv
`timescale 1ns/10ps
`include "crau_defs.svh"
// pure address and permission check, shared by reads and writes
module crau_check
   import crau_pkg::*;
(
   input  wire logic [31:0]             addr,
   input  wire logic                    is_write,
   output wire crau_fault_t             fault,
   output wire logic [`CRAU_IDX_W-1:0]  index
);
   wire logic                   in_space;
   wire logic                   defined;
   wire logic                   allowed;
   wire logic [`CRAU_NREG-1:0]  allow_mask;

   assign in_space   = (addr & `CRAU_BASE_MASK) == `CRAU_BASE;
   assign index      = addr[`CRAU_IDX_LSB +: `CRAU_IDX_W];
   assign defined    = in_space && (index < `CRAU_NDEF);
   assign allow_mask = is_write ? `CRAU_WR_ALLOW : `CRAU_RD_ALLOW;
   assign allowed    = allow_mask[index];
   // mapping is judged before permission
   assign fault = !defined ? CRAU_FAULT_UNMAPPED :                    // R2 R4
                  !allowed ? CRAU_FAULT_PERMISSION : CRAU_FAULT_NONE; // R3 R4
endmodule

// ### design/crau_unit.sv
`timescale 1ns/10ps
`include "crau_defs.svh"
// Functional notes
// R1: control register accesses are 32-bit words only
// R2: unmapped read address raises fault with address
// R3: mapped read checks read permission after mapping
// R4: writes check mapping, then write permission
// R5: successful read returns indexed register content
// R6: successful write stores word at indexed register
// R7: masked status update merges bits, flushes pipeline
// R8: interrupt return restores saved state, flushes pipeline
// R9: instruction sync flushes pipeline, discards fetched syllables
// R10: lock wait stalls until lock clear or interrupt
// R11: retention procedure enters low power retention
// R12: checks precommit; commit only without bundle exception
// R13: faulting access returns nothing, modifies nothing
module crau_unit
   import crau_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         req_valid,
   input  wire crau_op_t     req_op,
   input  wire logic [31:0]  req_addr,
   input  wire logic [2:0]   req_bytes,
   input  wire logic [31:0]  req_wdata,
   input  wire logic [31:0]  req_mask,
   input  wire logic         bundle_fault,
   input  wire logic         irq_pending,
   input  wire logic         lock_clear,
   input  wire logic         wake,
   output logic              resp_valid,
   output logic [31:0]       resp_rdata,
   output logic              fault_valid,
   output crau_fault_t       fault_kind,
   output logic [31:0]       fault_addr,
   output logic              pipe_flush,
   output logic              fetch_discard,
   output logic              stall,
   output logic              retention,
   output logic [31:0]       program_status_word
);
   typedef enum logic [1:0]
   {
      CRAU_IDLE,
      CRAU_LOCK_WAIT,
      CRAU_RETAIN
   } crau_state_t;

   crau_state_t                  state;
   crau_state_t                  next_state;
   logic [31:0]                  control_register_file [`CRAU_NREG];
   wire crau_fault_t             chk_fault;
   wire crau_fault_t             eff_fault;
   wire logic [`CRAU_IDX_W-1:0]  idx;
   wire logic                    is_rd;
   wire logic                    is_wr;
   wire logic                    is_acc;
   wire logic                    commit;
   wire logic                    do_wr;
   wire logic                    do_psw;
   wire logic                    do_rfi;
   wire logic                    flush_op;
   wire logic                    lock_held;
   wire logic                    accept;
   wire logic [31:0]             psw_cur;
   wire logic [31:0]             next_psw;
   wire logic                    do_sync;
   wire logic                    do_lock;
   wire logic                    do_retain;
   wire logic                    acc_fault;
   wire logic                    next_resp_valid;
   wire logic [31:0]             next_resp_rdata;
   wire logic                    next_fault_valid;
   wire crau_fault_t             next_fault_kind;
   wire logic [31:0]             next_fault_addr;
   wire logic                    next_pipe_flush;
   wire logic                    next_fetch_discard;
   wire logic                    next_stall;
   wire logic                    next_retention;
   wire logic [31:0]             next_status;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] sel);
      merge = (old_v & ~sel) | (new_v & sel);
   endfunction

   crau_check u_check
   (
      .addr     (req_addr),
      .is_write (is_wr),
      .fault    (chk_fault),
      .index    (idx)
   );

   // no new request is taken while stalled or retained
   assign accept    = req_valid && (state == CRAU_IDLE);
   assign is_rd     = accept && (req_op == CRAU_OP_READ);
   assign is_wr     = accept && (req_op == CRAU_OP_WRITE);
   assign is_acc    = is_rd || is_wr;
   // narrower or wider transfers are treated as unmapped
   assign eff_fault = (req_bytes != `CRAU_WORD_BYTES) ? CRAU_FAULT_UNMAPPED : chk_fault; // R1
   // another fault in the bundle vetoes every commit
   assign commit    = !bundle_fault && (!is_acc || eff_fault == CRAU_FAULT_NONE);      // R12 R13
   assign do_wr     = is_wr && commit && (eff_fault == CRAU_FAULT_NONE);                // R6 R13
   assign do_psw    = accept && commit && (req_op == CRAU_OP_MASKED_STATUS_UPDATE);
   assign do_rfi    = accept && commit && (req_op == CRAU_OP_RFI);
   assign do_sync   = accept && commit && (req_op == CRAU_OP_ISYNC);                    // R9
   assign do_lock   = accept && commit && (req_op == CRAU_OP_LOCKWAIT);                 // R10
   assign do_retain = accept && commit && (req_op == CRAU_OP_RETAIN);                   // R11
   assign flush_op  = do_psw || do_rfi || do_sync;                                      // R7 R8 R9
   assign lock_held = control_register_file[`CRAU_LOCK_IDX][`CRAU_LOCK_BIT];
   assign psw_cur   = control_register_file[`CRAU_PSW_IDX];
   assign next_psw  = do_rfi ? control_register_file[`CRAU_SAVED_IDX] :                 // R8
                      merge(psw_cur, req_wdata, req_mask);                              // R7

   always_comb
   begin
      next_state = state;
      case (state)
         CRAU_IDLE:
         begin
            if (do_lock && lock_held && !irq_pending)
               next_state = CRAU_LOCK_WAIT; // R10
            else if (do_retain)
               next_state = CRAU_RETAIN; // R11
         end
         CRAU_LOCK_WAIT:
         begin
            if (!lock_held || lock_clear || irq_pending)
               next_state = CRAU_IDLE; // R10
         end
         CRAU_RETAIN:
         begin
            if (wake || irq_pending)
               next_state = CRAU_IDLE;
         end
         default:
            next_state = CRAU_IDLE;
      endcase
   end

   // read data is zero unless a response stands, so stale contents never leak
   assign acc_fault          = is_acc && (eff_fault != CRAU_FAULT_NONE);              // R2 R3 R4
   assign next_resp_valid    = is_rd && commit;                                       // R5 R13
   assign next_resp_rdata    = next_resp_valid ? control_register_file[idx] : `CRAU_ZERO; // R5
   assign next_fault_valid   = acc_fault;
   assign next_fault_kind    = is_acc ? eff_fault : CRAU_FAULT_NONE;
   assign next_fault_addr    = acc_fault ? req_addr : `CRAU_ZERO;                     // R2
   assign next_pipe_flush    = flush_op;                                              // R7 R8 R9
   assign next_fetch_discard = do_sync;                                               // R9
   assign next_stall         = next_state == CRAU_LOCK_WAIT;                          // R10
   assign next_retention     = next_state == CRAU_RETAIN;                             // R11
   assign next_status        = (do_psw || do_rfi) ? next_psw : psw_cur;

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         state <= CRAU_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < `CRAU_NREG; i++)
            control_register_file[i] <= `CRAU_ZERO;
         control_register_file[`CRAU_ID_IDX] <= `CRAU_ID_VALUE;
      end
      else
      begin
         // lock bit cleared by the outside; the clear yields to a same-cycle write
         if (lock_clear)
            control_register_file[`CRAU_LOCK_IDX][`CRAU_LOCK_BIT] <= 1'b0;
         if (do_wr)
            control_register_file[idx] <= req_wdata; // R6
         if (do_psw || do_rfi)
            control_register_file[`CRAU_PSW_IDX] <= next_psw; // R7 R8
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         resp_valid  <= 1'b0;
         resp_rdata  <= `CRAU_ZERO;
         fault_valid <= 1'b0;
         fault_kind  <= CRAU_FAULT_NONE;
         fault_addr  <= `CRAU_ZERO;
      end
      else
      begin
         resp_valid  <= next_resp_valid;
         resp_rdata  <= next_resp_rdata;
         fault_valid <= next_fault_valid;
         fault_kind  <= next_fault_kind;
         fault_addr  <= next_fault_addr;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         pipe_flush          <= 1'b0;
         fetch_discard       <= 1'b0;
         stall               <= 1'b0;
         retention           <= 1'b0;
         program_status_word <= `CRAU_PSW_RESET;
      end
      else
      begin
         pipe_flush          <= next_pipe_flush;
         fetch_discard       <= next_fetch_discard;
         stall               <= next_stall;
         retention           <= next_retention;
         program_status_word <= next_status;
      end
   end
endmodule

// ### verification/crau_unit_props.sv
`timescale 1ns/10ps
`include "crau_defs.svh"
module crau_unit_props
   import crau_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        req_valid,
   input wire crau_op_t    req_op,
   input wire logic [31:0] req_addr,
   input wire logic [2:0]  req_bytes,
   input wire logic        bundle_fault,
   input wire logic        irq_pending,
   input wire logic        lock_clear,
   input wire logic        resp_valid,
   input wire logic        fault_valid,
   input wire crau_fault_t fault_kind,
   input wire logic [31:0] fault_addr,
   input wire logic        pipe_flush,
   input wire logic        fetch_discard,
   input wire logic        stall,
   input wire logic        retention
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire take    = req_valid && !stall && !retention;
   wire commit  = take && !bundle_fault;
   wire in_sp   = (req_addr & `CRAU_BASE_MASK) == `CRAU_BASE;
   wire is_acc  = req_op == CRAU_OP_READ || req_op == CRAU_OP_WRITE;
   chk_unmapped_read: assert property (take && req_op == CRAU_OP_READ && !in_sp |=>
      fault_valid && fault_kind == CRAU_FAULT_UNMAPPED && fault_addr == $past(req_addr))
      else $error("unmapped read not faulted");
   chk_id_write_perm: assert property (take && req_op == CRAU_OP_WRITE && req_addr == 32'hFFFF0010
      && req_bytes == 3'h4 |=> fault_valid && fault_kind == CRAU_FAULT_PERMISSION)
      else $error("id write not refused");
   chk_fault_no_data: assert property (fault_valid |-> !resp_valid)
      else $error("fault with read data");
   chk_word_only: assert property (take && is_acc && req_bytes != 3'h4 |=> fault_valid)
      else $error("narrow access accepted");
   chk_flush_ops: assert property (commit && req_op inside {CRAU_OP_MASKED_STATUS_UPDATE, CRAU_OP_RFI,
      CRAU_OP_ISYNC} |=> pipe_flush) else $error("no pipeline flush");
   chk_discard_sync: assert property (fetch_discard |-> pipe_flush && $past(req_op) == CRAU_OP_ISYNC)
      else $error("fetch discard without sync");
   chk_bundle_veto: assert property (take && bundle_fault |=> !resp_valid && !pipe_flush
      && !retention) else $error("commit despite bundle fault");
   chk_lock_exit: assert property (stall && (lock_clear || irq_pending) |=> !stall)
      else $error("lock wait not ended");
   chk_retain_entry: assert property (commit && req_op == CRAU_OP_RETAIN |=> retention)
      else $error("retention not entered");
   cov_read: cover property (commit && req_op == CRAU_OP_READ ##1 resp_valid);
   cov_stall: cover property (stall ##1 !stall);
   cov_retain: cover property (retention ##1 !retention);
endmodule
bind crau_unit crau_unit_props u_props (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
   .req_op(req_op), .req_addr(req_addr), .req_bytes(req_bytes), .bundle_fault(bundle_fault),
   .irq_pending(irq_pending), .lock_clear(lock_clear), .resp_valid(resp_valid),
   .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_addr(fault_addr),
   .pipe_flush(pipe_flush), .fetch_discard(fetch_discard), .stall(stall), .retention(retention));

// ### verification/crau_lsu_model.sv
`timescale 1ns/10ps
module crau_lsu_model
   import crau_pkg::*;
(
   input  wire logic  core_clk,
   output logic       req_valid,
   output crau_op_t   req_op,
   output logic [31:0] req_addr,
   output logic [2:0] req_bytes,
   output logic [31:0] req_wdata,
   output logic [31:0] req_mask,
   output logic       bundle_fault
);
   initial {req_valid, req_addr, req_bytes, req_wdata, req_mask, bundle_fault} = '0;
   initial req_op = CRAU_OP_NONE;
   // one-cycle strobe; released address and write data flip so stale values never look valid
   task automatic issue(input crau_op_t op, input logic [31:0] a, input logic [2:0] n,
                        input logic [31:0] d, input logic [31:0] m, input logic bf);
      @(negedge core_clk);
      req_valid    = 1'b1;
      req_op       = op;
      req_addr     = a;
      req_bytes    = n;
      req_wdata    = d;
      req_mask     = m;
      bundle_fault = bf;
      @(negedge core_clk);
      req_valid    = 1'b0;
      req_op       = CRAU_OP_NONE;
      req_addr     = ~a;
      req_wdata    = ~d;
      bundle_fault = 1'b0;
   endtask
endmodule

// ### verification/crau_unit_tb_top.sv
`timescale 1ns/10ps
`include "crau_defs.svh"
module crau_unit_tb_top
   import crau_pkg::*;
;
   logic core_clk = 0, nrst = 0, irq_pending = 0, lock_clear = 0, wake = 0;
   logic req_valid, resp_valid, fault_valid, pipe_flush, fetch_discard;
   logic stall, retention, bundle_fault;
   crau_op_t req_op;
   crau_fault_t fault_kind;
   logic [2:0] req_bytes;
   logic [31:0] req_addr, req_wdata, req_mask, resp_rdata, fault_addr, program_status_word;
   int n_errors = 0, checks_done = 0;
   initial forever #2.5 core_clk = ~core_clk;
   crau_lsu_model lsu (.core_clk(core_clk), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_bytes(req_bytes), .req_wdata(req_wdata), .req_mask(req_mask),
      .bundle_fault(bundle_fault));
   crau_unit dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_bytes(req_bytes), .req_wdata(req_wdata), .req_mask(req_mask),
      .bundle_fault(bundle_fault), .irq_pending(irq_pending), .lock_clear(lock_clear),
      .wake(wake), .resp_valid(resp_valid), .resp_rdata(resp_rdata), .fault_valid(fault_valid),
      .fault_kind(fault_kind), .fault_addr(fault_addr), .pipe_flush(pipe_flush),
      .fetch_discard(fetch_discard), .stall(stall), .retention(retention),
      .program_status_word(program_status_word));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         n_errors++;
      end
   endtask
   task rd(input logic [31:0] a, input logic [2:0] n);
      lsu.issue(CRAU_OP_READ, a, n, 32'h0, 32'h0, 1'b0);
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] n);
      lsu.issue(CRAU_OP_WRITE, a, n, d, 32'h0, 1'b0);
   endtask
   task t_access;
      wr(32'hFFFF0014, 32'h12345678, 3'h4);
      wr(32'hFFFF0014, 32'hDEADBEEF, 3'h2);
      chk("narrow fault", 32'(fault_valid), 32'h1);
      chk("narrow kind", 32'(fault_kind), 32'(CRAU_FAULT_UNMAPPED));
      lsu.issue(CRAU_OP_WRITE, 32'hFFFF0014, 3'h4, 32'h0BADF00D, 32'h0, 1'b1);
      chk("veto fault", 32'(fault_valid), 32'h0);
      rd(32'hFFFF0014, 3'h4);
      chk("reg5 data", resp_rdata, 32'h12345678);
      wr(32'h00001000, 32'h00000001, 3'h4);
      chk("unmapped wr", 32'(fault_kind), 32'(CRAU_FAULT_UNMAPPED));
      wr(32'hFFFF0010, 32'h0000FFFF, 3'h4);
      chk("id write kind", 32'(fault_kind), 32'(CRAU_FAULT_PERMISSION));
      rd(32'hFFFF0010, 3'h4);
      chk("id data", resp_rdata, `CRAU_ID_VALUE);
      chk("id fault", 32'(fault_valid), 32'h0);
      rd(32'hFFFF0028, 3'h4);
      chk("undef fault", 32'(fault_valid), 32'h1);
      chk("undef addr", fault_addr, 32'hFFFF0028);
      chk("undef resp", 32'(resp_valid), 32'h0);
      $display("test access done");
   endtask
   task t_state;
      lsu.issue(CRAU_OP_MASKED_STATUS_UPDATE, 32'h0, 3'h4, 32'hFFFFFFFF, 32'h000000F0, 1'b0);
      chk("psw merge", program_status_word, 32'h000000F0);
      chk("psw flush", 32'(pipe_flush), 32'h1);
      lsu.issue(CRAU_OP_MASKED_STATUS_UPDATE, 32'h0, 3'h4, 32'h0, 32'h000000FF, 1'b1);
      chk("psw veto", program_status_word, 32'h000000F0);
      chk("veto flush", 32'(pipe_flush), 32'h0);
      wr(32'hFFFF0004, 32'h00000123, 3'h4);
      lsu.issue(CRAU_OP_RFI, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("rfi psw", program_status_word, 32'h00000123);
      chk("rfi flush", 32'(pipe_flush), 32'h1);
      lsu.issue(CRAU_OP_ISYNC, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("sync discard", 32'(fetch_discard), 32'h1);
      chk("sync flush", 32'(pipe_flush), 32'h1);
      $display("test state done");
   endtask
   task t_wait;
      wr(32'hFFFF000C, 32'h00000001, 3'h4);
      lsu.issue(CRAU_OP_LOCKWAIT, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("stall on", 32'(stall), 32'h1);
      rd(32'hFFFF0014, 3'h4);
      chk("refused", 32'(resp_valid), 32'h0);
      lock_clear = 1;
      @(negedge core_clk);
      lock_clear = 0;
      chk("stall off", 32'(stall), 32'h0);
      lsu.issue(CRAU_OP_RETAIN, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("retain on", 32'(retention), 32'h1);
      wake = 1;
      @(negedge core_clk);
      wake = 0;
      chk("retain off", 32'(retention), 32'h0);
      lsu.issue(CRAU_OP_LOCKWAIT, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("no lock stall", 32'(stall), 32'h0);
      wr(32'hFFFF000C, 32'h00000001, 3'h4);
      lsu.issue(CRAU_OP_LOCKWAIT, 32'h0, 3'h4, 32'h0, 32'h0, 1'b0);
      chk("stall again", 32'(stall), 32'h1);
      irq_pending = 1;
      @(negedge core_clk);
      irq_pending = 0;
      chk("irq ends wait", 32'(stall), 32'h0);
      rd(32'hFFFF000C, 3'h4);
      chk("lock kept", resp_rdata, 32'h00000001);
      $display("test wait done");
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge core_clk);
      nrst = 1;
      t_access();
      t_state();
      t_wait();
      results();
   end
endmodule
